// ---- hw/sfb_serial_port.v ----
// Serial port with control flags, shared data buffer and APB registers.
`timescale 1ns/1ps
`include "sfb_consts.vh"

// Operation
// RL1 - Nine-bit modes transmit the tx_ninth_bit field as ninth data bit.
// RL2 - Nine-bit modes store the received ninth bit into rx_ninth_bit.
// RL3 - Mode 1 with multiproc_filter clear stores the stop bit in rx_ninth_bit.
// RL4 - tx_done_flag sets after bit eight in mode 0, else at stop start.
// RL5 - rx_done_flag sets after bit eight in mode 0, else at stop sample.
// RL6 - One shared byte buffer; a software write starts a transmission.
// RL7 - Reading the buffer returns the last received byte.
// RL8 - Two mode bits pick shift, 8-bit async, fixed 9-bit, variable 9-bit.
// RL9 - Nine-bit modes with filter set ignore frames whose ninth bit is zero.
// RL10 - Mode 1 raises receive done only on a valid stop bit.
// RL11 - Reception runs only while the receive enable bit is one; the code checks it only to start a frame.
module sfb_serial_port (
    input  wire        clock,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    output reg         txd,
    input  wire        rxdIn,
    output reg         rxdOut,
    output reg         rxdOe
);

    // ****************************************
    // Register decode
    // ****************************************
    localparam SEL_NONE = 3'h0;
    localparam SEL_CTL  = 3'h1;
    localparam SEL_BUF  = 3'h2;
    localparam SEL_BAUD = 3'h3;
    localparam SEL_IST  = 3'h4;
    localparam SEL_IMSK = 3'h5;

    function [2:0] regSel;
        input [11:0] addr;
        begin
            if (addr == `SFB_ADDR_CONTROL)
                regSel = SEL_CTL;
            else if (addr == `SFB_ADDR_BUFFER)
                regSel = SEL_BUF;
            else if (addr == `SFB_ADDR_BAUD)
                regSel = SEL_BAUD;
            else if (addr == `SFB_ADDR_INTSTAT)
                regSel = SEL_IST;
            else if (addr == `SFB_ADDR_INTMASK)
                regSel = SEL_IMSK;
            else
                regSel = SEL_NONE;
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg  [7:0] control;
    reg  [7:0] rxBuffer;
    reg  [8:0] baud;
    reg  [1:0] intStatus;
    reg  [1:0] intMask;
    reg        rxMeta;
    reg        rxSync;
    reg        rxPrev;
    reg        txState;
    reg [10:0] txShift;
    reg  [3:0] txLeft;
    reg  [3:0] txSub;
    reg        rxState;
    reg  [9:0] rxShift;
    reg  [3:0] rxLeft;
    reg  [3:0] rxTotal;
    reg  [3:0] rxSub;
    reg        txDoneSet;
    reg        rxDoneSet;
    reg        next_txd;
    wire       tick;
    wire       wrEn;
    wire [2:0] wrSel;
    wire [1:0] mode;
    wire       shiftMode;
    wire       rxSample;

    assign wrEn      = psel & penable & pready & pwrite;
    assign wrSel     = regSel(paddr);
    // RL8 - Mode bits decode.
    assign mode      = {control[`SFB_CTL_MODE_HI], control[`SFB_CTL_MODE_LO]};
    assign shiftMode = (mode == `SFB_MODE_SHIFT);
    assign rxSample  = (rxSub == `SFB_SAMPLE_POINT);

    sfb_tick u_tick (
        .clock      (clock),
        .rst_b      (rst_b),
        .mode       (mode),
        .doubleRate (baud[`SFB_BAUD_DOUBLE]),
        .baudDiv    (baud[7:0]),
        .tick       (tick)
    );

    // ****************************************
    // APB slave
    // ****************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (regSel(paddr) == SEL_NONE);
            prdata  <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                if (regSel(paddr) == SEL_CTL)
                    prdata <= {24'h000000, control};
                // RL7 - Buffer reads return received data.
                else if (regSel(paddr) == SEL_BUF)
                    prdata <= {24'h000000, rxBuffer};
                else if (regSel(paddr) == SEL_BAUD)
                    prdata <= {23'h000000, baud};
                else if (regSel(paddr) == SEL_IST)
                    prdata <= {30'h00000000, intStatus};
                else if (regSel(paddr) == SEL_IMSK)
                    prdata <= {30'h00000000, intMask};
            end
        end
    end

    // ****************************************
    // Control, baud and interrupt registers
    // ****************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            control <= `SFB_CTL_RESET;
            baud    <= `SFB_BAUD_RESET;
            intMask <= 2'h0;
        end else begin
            if (wrEn && wrSel == SEL_CTL)
                control[7:2] <= pwdata[7:2];
            if (wrEn && wrSel == SEL_BAUD)
                baud <= pwdata[8:0];
            if (wrEn && wrSel == SEL_IMSK)
                intMask <= pwdata[1:0];
            // RL4 - Hardware set wins over software clear.
            if (txDoneSet)
                control[`SFB_CTL_TXDONE] <= 1'b1;
            else if (wrEn && wrSel == SEL_CTL)
                control[`SFB_CTL_TXDONE] <= pwdata[`SFB_CTL_TXDONE];
            // RL5 - Hardware set wins over software clear.
            if (rxDoneSet)
                control[`SFB_CTL_RXDONE] <= 1'b1;
            else if (wrEn && wrSel == SEL_CTL)
                control[`SFB_CTL_RXDONE] <= pwdata[`SFB_CTL_RXDONE];
            // RL2 - Ninth bit capture in nine-bit modes.
            if (rxDoneSet && (mode == `SFB_MODE_FIXED9 ||
                              mode == `SFB_MODE_VAR9))
                control[`SFB_CTL_RX9] <= rxShift[9];
            // RL3 - Stop bit capture in mode 1.
            else if (rxDoneSet && mode == `SFB_MODE_ASYNC8 &&
                     !control[`SFB_CTL_MPFILTER])
                control[`SFB_CTL_RX9] <= rxSync;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sticky
            wire evt = (gi == `SFB_INT_TX) ? txDoneSet : rxDoneSet;
            always @(posedge clock) begin
                if (!rst_b)
                    intStatus[gi] <= 1'b0;
                else if (evt)
                    intStatus[gi] <= 1'b1;
                else if (wrEn && wrSel == SEL_IST && pwdata[gi])
                    intStatus[gi] <= 1'b0;
            end
        end
    endgenerate

    always @(posedge clock) begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(intStatus & intMask);
    end

    // ****************************************
    // Receive pin synchroniser
    // ****************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
            rxPrev <= 1'b1;
        end else begin
            rxMeta <= rxdIn;
            rxSync <= rxMeta;
            rxPrev <= rxSync;
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            txState   <= ST_IDLE;
            txShift   <= 11'h7ff;
            txLeft    <= 4'h0;
            txSub     <= 4'h0;
            txDoneSet <= 1'b0;
        end else begin
            txDoneSet <= 1'b0;
            case (txState)
            ST_IDLE: begin
                // RL6 - Buffer write starts a frame.
                if (wrEn && wrSel == SEL_BUF) begin
                    txState <= ST_BUSY;
                    txSub   <= 4'h0;
                    if (shiftMode) begin
                        txShift <= {3'h7, pwdata[7:0]};
                        txLeft  <= `SFB_SHIFT_BITS;
                    end else if (mode == `SFB_MODE_ASYNC8) begin
                        txShift <= {2'h3, pwdata[7:0], 1'b0};
                        txLeft  <= `SFB_FRAME_8;
                    end else begin
                        // RL1 - Ninth bit from the control field.
                        txShift <= {1'b1, control[`SFB_CTL_TX9],
                                    pwdata[7:0], 1'b0};
                        txLeft  <= `SFB_FRAME_9;
                    end
                end
            end
            default: begin
                if (shiftMode) begin
                    txSub <= txSub + 4'h1;
                    if (txSub[0]) begin
                        txShift <= {1'b1, txShift[10:1]};
                        txLeft  <= txLeft - 4'h1;
                        // RL4 - Mode 0 done after the eighth bit.
                        if (txLeft == 4'h1) begin
                            txDoneSet <= 1'b1;
                            txState   <= ST_IDLE;
                        end
                    end
                end else if (tick) begin
                    txSub <= txSub + 4'h1;
                    if (txSub == `SFB_SUB_LAST) begin
                        txShift <= {1'b1, txShift[10:1]};
                        txLeft  <= txLeft - 4'h1;
                        // RL4 - Done as the stop bit begins.
                        if (txLeft == 4'h2)
                            txDoneSet <= 1'b1;
                        if (txLeft == 4'h1)
                            txState <= ST_IDLE;
                    end
                end
            end
            endcase
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            rxState   <= ST_IDLE;
            rxShift   <= 10'h000;
            rxLeft    <= 4'h0;
            rxTotal   <= 4'h0;
            rxSub     <= 4'h0;
            rxBuffer  <= 8'h00;
            rxDoneSet <= 1'b0;
        end else begin
            rxDoneSet <= 1'b0;
            case (rxState)
            ST_IDLE: begin
                rxSub <= 4'h0;
                // RL11 - Receiver starts only when enabled.
                if (control[`SFB_CTL_RXEN]) begin
                    if (shiftMode) begin
                        if (!control[`SFB_CTL_RXDONE] &&
                            txState == ST_IDLE) begin
                            rxState <= ST_BUSY;
                            rxLeft  <= `SFB_SHIFT_BITS;
                        end
                    end else if (rxPrev && !rxSync) begin
                        rxState <= ST_BUSY;
                        rxTotal <= (mode == `SFB_MODE_ASYNC8) ?
                                   `SFB_FRAME_8 : `SFB_FRAME_9;
                        rxLeft  <= (mode == `SFB_MODE_ASYNC8) ?
                                   `SFB_FRAME_8 : `SFB_FRAME_9;
                    end
                end
            end
            default: begin
                if (shiftMode) begin
                    rxSub <= rxSub + 4'h1;
                    if (rxSub[0]) begin
                        rxShift <= {rxSync, rxShift[9:1]};
                        rxLeft  <= rxLeft - 4'h1;
                        // RL5 - Mode 0 done after the eighth bit.
                        if (rxLeft == 4'h1) begin
                            rxBuffer  <= {rxSync, rxShift[9:3]};
                            rxDoneSet <= 1'b1;
                            rxState   <= ST_IDLE;
                        end
                    end
                end else if (tick) begin
                    rxSub <= rxSub + 4'h1;
                    if (rxSample) begin
                        rxLeft <= rxLeft - 4'h1;
                        if (rxLeft == rxTotal && rxSync)
                            rxState <= ST_IDLE;
                        else if (rxLeft != 4'h1)
                            rxShift <= {rxSync, rxShift[9:1]};
                        else begin
                            rxState <= ST_IDLE;
                            if (mode == `SFB_MODE_ASYNC8) begin
                                // RL10 - Mode 1 needs a valid stop bit.
                                if (rxSync) begin
                                    rxBuffer  <= rxShift[9:2];
                                    rxDoneSet <= 1'b1;
                                end
                            // RL9 - Filter drops frames with ninth bit zero.
                            end else if (!(control[`SFB_CTL_MPFILTER] &&
                                           !rxShift[9])) begin
                                // RL5 - Done at the stop sampling point.
                                rxBuffer  <= rxShift[8:1];
                                rxDoneSet <= 1'b1;
                            end
                        end
                    end
                end
            end
            endcase
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always @* begin
        next_txd = 1'b1;
        if (shiftMode) begin
            if (txState == ST_BUSY)
                next_txd = txSub[0];
            else if (rxState == ST_BUSY)
                next_txd = rxSub[0];
        end else if (txState == ST_BUSY) begin
            next_txd = txShift[0];
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            txd    <= 1'b1;
            rxdOut <= 1'b1;
            rxdOe  <= 1'b0;
        end else begin
            txd    <= next_txd;
            rxdOut <= txShift[0];
            rxdOe  <= shiftMode & (txState == ST_BUSY);
        end
    end

endmodule // sfb_serial_port

// ---- hw/sfb_consts.vh ----
// Constants for the serial port flags and data buffer block.
`ifndef SFB_CONSTS_VH
`define SFB_CONSTS_VH

// ****************************************
// Register indexes and byte addresses
// ****************************************
`define SFB_IDX_CONTROL   8'h98
`define SFB_IDX_BUFFER    8'h99
`define SFB_IDX_BAUD      8'h9a
`define SFB_IDX_INTSTAT   8'h9b
`define SFB_IDX_INTMASK   8'h9c
`define SFB_ADDR_WIDTH    12
`define SFB_ADDR_CONTROL  12'h260
`define SFB_ADDR_BUFFER   12'h264
`define SFB_ADDR_BAUD     12'h268
`define SFB_ADDR_INTSTAT  12'h26c
`define SFB_ADDR_INTMASK  12'h270

// ****************************************
// Control register fields
// ****************************************
`define SFB_CTL_MODE_HI   7
`define SFB_CTL_MODE_LO   6
`define SFB_CTL_MPFILTER  5
`define SFB_CTL_RXEN      4
`define SFB_CTL_TX9       3
`define SFB_CTL_RX9       2
`define SFB_CTL_TXDONE    1
`define SFB_CTL_RXDONE    0
`define SFB_CTL_RESET     8'h00

// ****************************************
// Modes, baud and interrupt fields
// ****************************************
`define SFB_MODE_SHIFT    2'h0
`define SFB_MODE_ASYNC8   2'h1
`define SFB_MODE_FIXED9   2'h2
`define SFB_MODE_VAR9     2'h3
`define SFB_BAUD_DOUBLE   8
`define SFB_BAUD_RESET    9'h000
`define SFB_RELOAD_FAST   8'h01
`define SFB_RELOAD_SLOW   8'h03
`define SFB_INT_TX        0
`define SFB_INT_RX        1
`define SFB_FRAME_8       4'ha
`define SFB_FRAME_9       4'hb
`define SFB_SHIFT_BITS    4'h8
`define SFB_SAMPLE_POINT  4'h7
`define SFB_SUB_LAST      4'hf

`endif

// ---- hw/sfb_tick.v ----
// Oversampling tick generator for the asynchronous modes.
`timescale 1ns/1ps
`include "sfb_consts.vh"

module sfb_tick (
    input  wire       clock,
    input  wire       rst_b,
    input  wire [1:0] mode,
    input  wire       doubleRate,
    input  wire [7:0] baudDiv,
    output reg        tick
);

    reg  [7:0] count;
    wire [7:0] reload;

    // Mode 2 gives 16 ticks per 32 or 64 clocks; others use the divider.
    assign reload = (mode == `SFB_MODE_FIXED9) ?
                    (doubleRate ? `SFB_RELOAD_FAST : `SFB_RELOAD_SLOW) :
                    baudDiv;

    always @(posedge clock) begin
        if (!rst_b) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (count == 8'h00) begin
            count <= reload;
            tick  <= 1'b1;
        end else begin
            count <= count - 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule // sfb_tick

// ---- test/sfb_serial_port_sva.sv ----
// Checker for the serial port bus, interrupt and pin behaviour.
`timescale 1ns/1ps
`include "sfb_consts.vh"

module sfb_serial_port_sva (
    input logic        clock,
    input logic        rst_b,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        irq,
    input logic        txd,
    input logic        rxdIn,
    input logic        rxdOut,
    input logic        rxdOe
);
    logic mapped;
    logic setup;
    assign mapped = paddr inside {`SFB_ADDR_CONTROL, `SFB_ADDR_BUFFER,
        `SFB_ADDR_BAUD, `SFB_ADDR_INTSTAT, `SFB_ADDR_INTMASK};
    assign setup = psel && !penable;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ********
    // Bus and pins
    // ********
    a_setup_answer:
        assert property (setup |=> pready) else $error("No bus answer.");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("Long ready.");
    a_map_error:
        assert property (setup |=> pslverr == !$past(mapped))
        else $error("Wrong bus error.");
    a_error_data:
        assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("Data with bus error.");
    a_buffer_byte:
        assert property (pready && !pwrite && paddr == `SFB_ADDR_BUFFER
            |-> prdata[31:8] == 24'h0) else $error("Wide buffer read.");
    a_irq_masked:
        assert property (pready && pwrite && paddr == `SFB_ADDR_INTMASK &&
            pwdata[1:0] == 2'h0 |=> ##1 !irq) else $error("Masked irq.");
    a_shift_low:
        assert property (rxdOe && $fell(txd) |=> txd)
        else $error("Long shift clock low.");
    a_reset_idle:
        assert property (disable iff (1'b0) !rst_b |=> txd && rxdOut &&
            !rxdOe && !irq && !pready) else $error("Busy in reset.");
    c_error: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_shift: cover property ($rose(rxdOe));
endmodule // sfb_serial_port_sva

bind sfb_serial_port sfb_serial_port_sva chk (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd),
    .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe));

// ---- test/sfb_remote_model.sv ----
// Remote serial device model that sends and watches frames on the pins.
`timescale 1ns/1ps

module sfb_remote_model #(
    parameter int BIT_CLKS = 32
) (
    input  logic clock,
    input  logic txd,
    input  logic rxdOut,
    input  logic rxdOe,
    output logic rxdIn
);
    logic [9:0] frame;
    logic [7:0] shiftData;
    int         frameCnt = 0;
    int         shiftCnt = 0;

    initial rxdIn = 1'b1;

    always begin
        @(negedge txd);
        if (!rxdOe) begin
            repeat (BIT_CLKS / 2) @(posedge clock);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CLKS) @(posedge clock);
                frame[i] = txd;
            end
            frameCnt++;
        end
    end

    always @(posedge clock) begin
        if (rxdOe && !txd) begin
            shiftData <= {rxdOut, shiftData[7:1]};
            shiftCnt <= shiftCnt + 1;
        end
    end

    task automatic send(input logic [8:0] d, input int nBits,
                        input logic stopBit);
        rxdIn <= 1'b0;
        repeat (BIT_CLKS) @(posedge clock);
        for (int i = 0; i < nBits; i++) begin
            rxdIn <= d[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
        rxdIn <= stopBit;
        repeat (BIT_CLKS) @(posedge clock);
        rxdIn <= 1'b1;
        repeat (BIT_CLKS) @(posedge clock);
    endtask
endmodule // sfb_remote_model

// ---- test/serial_port_flags_buffer_bench.sv ----
// Self-checking bench for the serial port flags and data buffer.
`timescale 1ns/1ps
`include "sfb_consts.vh"

`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module serial_port_flags_buffer_bench;
    localparam logic [11:0] ACTL = `SFB_ADDR_CONTROL;
    localparam logic [11:0] ABUF = `SFB_ADDR_BUFFER;
    localparam logic [11:0] ASTAT = `SFB_ADDR_INTSTAT;
    localparam logic [11:0] AMASK = `SFB_ADDR_INTMASK;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic        txd, rxdIn, rxdOut, rxdOe, err, nin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctlRd;
    logic [7:0]  data, last;
    logic [4:0]  c;
    int          cnt, errors, n_checks;
    logic [4:0]  rxCases [7] = '{5'b01011, 5'b10010, 5'b11111, 5'b11110,
                                 5'b01010, 5'b01001, 5'b11011};

    sfb_serial_port uut (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd),
        .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe));

    // Divider one with the fast fixed rate gives 32 clocks a bit.
    sfb_remote_model #(.BIT_CLKS(32)) remote (
        .clock(clock), .txd(txd), .rxdOut(rxdOut), .rxdOe(rxdOe),
        .rxdIn(rxdIn));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic f,
                                        input logic en, input logic t9);
        return {24'h0, m, f, en, t9, 3'h0};
    endfunction

    function automatic logic rxFlag(input logic [4:0] cs);
        if (!cs[1])
            return 1'b0;
        if (cs[4:3] == `SFB_MODE_ASYNC8)
            return cs[0];
        return !cs[2] || cs[0];
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitFlag(input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, ACTL, 32'h0);
            k++;
        end while (rd[b] !== 1'b1 && k < 200);
    endtask

    task automatic conclude;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        conclude;
    end

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        last = 8'h00;
        void'($urandom(60330));
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, ACTL, 32'h0);
        `CHK(rd, {24'h0, `SFB_CTL_RESET})
        apb(1'b1, 12'h274, 32'hff);
        apb(1'b0, 12'h274, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `SFB_ADDR_BAUD, 32'h101);
        $display("test reset done");
        for (int m = 1; m < 4; m++) begin
            data = 8'($urandom);
            nin = 1'($urandom);
            cnt = remote.frameCnt;
            apb(1'b1, AMASK, (m == 1) ? 32'h0 : 32'h3);
            apb(1'b1, ACTL, ctl(2'(m), 1'b0, 1'b0, nin));
            apb(1'b1, ABUF, {24'h0, data});
            apb(1'b0, ACTL, 32'h0);
            `CHK(rd[`SFB_CTL_TXDONE], 1'b0)
            waitFlag(`SFB_CTL_TXDONE);
            `CHK(remote.frameCnt, cnt)
            for (int k = 0; k < 600 && remote.frameCnt == cnt; k++)
                @(posedge clock);
            `CHK(remote.frame, {1'b1, (m == 1) ? 1'b1 : nin, data})
            `CHK(irq, (m != 1))
            apb(1'b0, ASTAT, 32'h0);
            `CHK(rd, 32'h1)
            apb(1'b1, ASTAT, 32'h3);
            repeat (3) @(posedge clock);
            `CHK(irq, 1'b0)
            // Let the stop bit run out before the next mode is set.
            repeat (40) @(posedge clock);
            $display("test tx mode %0d done", m);
        end
        apb(1'b1, AMASK, 32'h3);
        foreach (rxCases[i]) begin
            c = rxCases[i];
            data = 8'($urandom);
            apb(1'b1, ACTL, ctl(c[4:3], c[2], c[1], 1'b0));
            remote.send({c[0], data}, (c[4:3] == 2'h1) ? 8 : 9,
                        (c[4:3] == 2'h1) ? c[0] : 1'b1);
            apb(1'b0, ACTL, 32'h0);
            ctlRd = rd;
            apb(1'b0, ABUF, 32'h0);
            if (rxFlag(c))
                last = data;
            `CHK(ctlRd[`SFB_CTL_RXDONE], rxFlag(c))
            `CHK(rd, {24'h0, last})
            `CHK(irq, rxFlag(c))
            if (rxFlag(c))
                `CHK(ctlRd[`SFB_CTL_RX9], c[0])
            apb(1'b1, ASTAT, 32'h3);
            $display("test rx case %0d done", i);
        end
        apb(1'b1, ABUF, {24'h0, ~last});
        apb(1'b0, ABUF, 32'h0);
        `CHK(rd, {24'h0, last})
        waitFlag(`SFB_CTL_TXDONE);
        // The done flag comes as the stop bit begins, so wait it out.
        repeat (40) @(posedge clock);
        cnt = remote.shiftCnt;
        data = 8'($urandom);
        apb(1'b1, ACTL, ctl(`SFB_MODE_SHIFT, 1'b0, 1'b0, 1'b0));
        apb(1'b1, ABUF, {24'h0, data});
        waitFlag(`SFB_CTL_TXDONE);
        `CHK(remote.shiftCnt - cnt, 8)
        `CHK(remote.shiftData, data)
        $display("test shift mode done");
        remote.rxdIn <= 1'b0;
        apb(1'b1, ACTL, ctl(`SFB_MODE_SHIFT, 1'b0, 1'b1, 1'b0));
        waitFlag(`SFB_CTL_RXDONE);
        `CHK(rd[`SFB_CTL_RXDONE], 1'b1)
        apb(1'b0, ABUF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, ASTAT, 32'h0);
        `CHK(rd[`SFB_INT_RX], 1'b1)
        remote.rxdIn <= 1'b1;
        $display("test shift receive done");
        conclude;
    end
endmodule // serial_port_flags_buffer_bench
